// file: rpc_far_model.sv
// Model of the far-end serializer feeding received pin levels.
// Assumes the bench commands the level pattern on the block clock.
`timescale 1ns/1ps
module rpc_far_model (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  // Level pattern the far end sends
  input  wire logic [4:0] lvl_i,
  // Levels as they arrive over the link
  output logic [4:0]      far_level_o
);
  // One cycle of link delay, so the block never sees a level early
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      far_level_o <= 5'h00; // Link idle after reset
    else
      far_level_o <= lvl_i;
  end
endmodule : rpc_far_model

// file: rpc_pin_config.sv
// Pin configuration block: APB registers and pad control for pins
// 3, 5, 6, 7, 8 and the second-port pin 3.
// Assumes synchronous pad inputs and far-end levels on ref_clk_i.
//
// Functional notes
// RULE1: Local level drives pin in local output
// RULE2: Far control forces output with far level
// RULE3: Far levels ignored when far control off
// RULE4: Code 00 func, 10 tristate, 01 out, 11 in
// RULE5: Port select moves pin 3 config
// RULE6: Pin 3 fields bits 3-0, upper reserved
// RULE7: Pin 5 low nibble, pin 6 high nibble
// RULE8: Pin 7 bits 3-1, pin 8 high, bit0 reserved
// RULE9: Reserved bits never affect pins
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module rpc_pin_config #(
  parameter int NP = rpc_pkg::NUM_PINS // Number of primary pins
) (
  // Clock and reset
  input  wire logic                      ref_clk_i,
  input  wire logic                      rst_i,
  // APB slave
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [rpc_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]               pwdata_i,
  input  wire logic [3:0]                pstrb_i,
  output logic [31:0]                    prdata_o,
  output logic                           pready_o,
  output logic                           pslverr_o,
  // Primary pins, order 3, 5, 6, 7, 8
  input  wire logic [NP-1:0]             pin_i,
  output logic [NP-1:0]                  pin_o,
  output logic [NP-1:0]                  pin_oe_n_o,
  input  wire logic [NP-1:0]             func_i,
  input  wire logic [NP-1:0]             far_level_i,
  // Second-port pin 3
  input  wire logic                      second_port_pin3_i,
  output logic                           second_port_pin3_o,
  output logic                           second_port_pin3_oe_n_o,
  input  wire logic                      second_port_func_i
);

  rpc_pkg::rpc_state_t state_ff;  // Registered state
  rpc_pkg::rpc_state_t nxt_state; // Next state
  logic                mapped;    // Address hits a register
  logic                wr_en;     // Write takes effect this edge
  logic                rd_setup;  // Read setup cycle
  rpc_pkg::rpc_cfg_t   cfg3_pri;  // Config seen by primary pin 3
  rpc_pkg::rpc_cfg_t   cfg3_sec;  // Config seen by second-port pin 3
  rpc_pkg::rpc_cfg_t   cfg7_full; // Pin 7 config with fixed enable

  // Pad decode shared by every pin
  function automatic rpc_pkg::rpc_pad_t pad_drive(
    input rpc_pkg::rpc_cfg_t c,
    input logic              func,
    input logic              far
  );
    rpc_pkg::rpc_pad_t p;
    p = '{out: 1'b0, oe_n: 1'b1};
    if (c.far_ctl)
    begin
      // Far end owns the pin; local code is overridden
      p = '{out: far, oe_n: 1'b0}; // RULE2
    end
    else
    begin
      // Far level not looked at on this path
      case (rpc_pkg::rpc_mode_t'({c.direction, c.func_en})) // RULE3 RULE4
        rpc_pkg::RPC_FUNC_OUT: p = '{out: func, oe_n: 1'b0};
        rpc_pkg::RPC_GP_OUT:   p = '{out: c.level, oe_n: 1'b0}; // RULE1
        rpc_pkg::RPC_TRISTATE: p = '{out: 1'b0, oe_n: 1'b1};
        rpc_pkg::RPC_GP_IN:    p = '{out: 1'b0, oe_n: 1'b1};
        default:               p = '{out: 1'b0, oe_n: 1'b1};
      endcase
    end
    return p;
  endfunction : pad_drive

  // Bus handshake: zero wait states, error on unmapped access
  assign mapped    = (paddr_i == rpc_pkg::ADDR_PIN3)  ||
                     (paddr_i == rpc_pkg::ADDR_PIN56) ||
                     (paddr_i == rpc_pkg::ADDR_PIN78) ||
                     (paddr_i == rpc_pkg::ADDR_PORT)  ||
                     (paddr_i == rpc_pkg::ADDR_LEVEL);
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~mapped;
  assign wr_en     = psel_i & penable_i & pwrite_i & mapped & pstrb_i[0];
  assign rd_setup  = psel_i & ~penable_i & ~pwrite_i;

  // Pin 7 has no enable bit, so it always sits in the pin mode
  assign cfg7_full = rpc_pkg::rpc_cfg_t'({state_ff.cfg7, 1'b1});
  // Port select steers the pin 3 nibble; the other side idles at zero
  assign cfg3_pri  = state_ff.port_sel ? '0 : state_ff.cfg3; // RULE5
  assign cfg3_sec  = state_ff.port_sel ? state_ff.cfg3 : '0; // RULE5

  // Next-state logic: registers, read data, pad drive, input sampling
  always_comb
  begin
    rpc_pkg::rpc_pad_t pd;
    nxt_state = state_ff;
    pd        = '{out: 1'b0, oe_n: 1'b1};
    // Register writes; only the low byte carries fields
    if (wr_en)
    begin
      case (paddr_i)
        rpc_pkg::ADDR_PIN3:
          nxt_state.cfg3 = pwdata_i[3:0]; // RULE6 RULE9
        rpc_pkg::ADDR_PIN56:
        begin
          nxt_state.cfg5 = pwdata_i[3:0]; // RULE7
          nxt_state.cfg6 = pwdata_i[7:4]; // RULE7
        end
        rpc_pkg::ADDR_PIN78:
        begin
          nxt_state.cfg7 = pwdata_i[3:1]; // RULE8 RULE9
          nxt_state.cfg8 = pwdata_i[7:4]; // RULE8
        end
        rpc_pkg::ADDR_PORT:
          nxt_state.port_sel = pwdata_i[0];
        default:
          nxt_state.port_sel = state_ff.port_sel;
      endcase
    end
    // Read data captured in setup so it is steady in the access phase
    if (rd_setup)
    begin
      case (paddr_i)
        rpc_pkg::ADDR_PIN3:  nxt_state.prdata = {28'h0, state_ff.cfg3};
        rpc_pkg::ADDR_PIN56: nxt_state.prdata =
                               {24'h0, state_ff.cfg6, state_ff.cfg5};
        rpc_pkg::ADDR_PIN78: nxt_state.prdata =
                               {24'h0, state_ff.cfg8, state_ff.cfg7, 1'b0};
        rpc_pkg::ADDR_PORT:  nxt_state.prdata = {31'h0, state_ff.port_sel};
        rpc_pkg::ADDR_LEVEL: nxt_state.prdata =
                               {{(31 - NP){1'b0}}, state_ff.in_lvl};
        default:             nxt_state.prdata = 32'h0;
      endcase
    end
    // Pad drive, registered so pin outputs never glitch
    pd = pad_drive(cfg3_pri, func_i[0], far_level_i[0]);
    nxt_state.pin_out[0]  = pd.out;
    nxt_state.pin_oe_n[0] = pd.oe_n;
    pd = pad_drive(state_ff.cfg5, func_i[1], far_level_i[1]);
    nxt_state.pin_out[1]  = pd.out;
    nxt_state.pin_oe_n[1] = pd.oe_n;
    pd = pad_drive(state_ff.cfg6, func_i[2], far_level_i[2]);
    nxt_state.pin_out[2]  = pd.out;
    nxt_state.pin_oe_n[2] = pd.oe_n;
    pd = pad_drive(cfg7_full, func_i[3], far_level_i[3]);
    nxt_state.pin_out[3]  = pd.out;
    nxt_state.pin_oe_n[3] = pd.oe_n;
    pd = pad_drive(state_ff.cfg8, func_i[4], far_level_i[4]);
    nxt_state.pin_out[4]  = pd.out;
    nxt_state.pin_oe_n[4] = pd.oe_n;
    // The far level follows the pin 3 nibble to whichever pad owns it
    pd = pad_drive(cfg3_sec, second_port_func_i, far_level_i[0]);
    nxt_state.sp_out  = pd.out;
    nxt_state.sp_oe_n = pd.oe_n;
    // Pad levels for software to read back in input mode
    nxt_state.in_lvl = {second_port_pin3_i, pin_i};
  end

  // State register; everything clears to zero
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // Outputs straight from flip-flops
  assign prdata_o                = state_ff.prdata;
  assign pin_o                   = state_ff.pin_out;
  assign pin_oe_n_o              = state_ff.pin_oe_n;
  assign second_port_pin3_o      = state_ff.sp_out;
  assign second_port_pin3_oe_n_o = state_ff.sp_oe_n;

  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_wr(logic [7:0] a);
    psel_i && penable_i && pwrite_i && pstrb_i[0] && paddr_i == a;
  endsequence

  sequence s_rd_setup(logic [7:0] a);
    psel_i && !penable_i && !pwrite_i && paddr_i == a;
  endsequence

  AST_LOCAL_LEVEL: assert property ( // RULE1
    (!state_ff.cfg5.far_ctl && !state_ff.cfg5.direction &&
     state_ff.cfg5.func_en)
    |=> (pin_o[1] == $past(state_ff.cfg5.level)) && !pin_oe_n_o[1])
    else $error("pin 5 not driving local level");

  AST_FAR_FORCE: assert property ( // RULE2
    state_ff.cfg6.far_ctl
    |=> !pin_oe_n_o[2] && (pin_o[2] == $past(far_level_i[2])))
    else $error("pin 6 not following far level");

  AST_FAR_IGNORED: assert property ( // RULE3
    (!state_ff.cfg8.far_ctl && !state_ff.cfg8.direction &&
     !state_ff.cfg8.func_en)
    |=> (pin_o[4] == $past(func_i[4])) && !pin_oe_n_o[4])
    else $error("pin 8 not on functional output");

  AST_TRISTATE: assert property ( // RULE4
    (!state_ff.cfg5.far_ctl && state_ff.cfg5.direction &&
     !state_ff.cfg5.func_en)
    |=> pin_oe_n_o[1] [*1])
    else $error("pin 5 driving in tri-state");

  AST_PORT_SEL: assert property ( // RULE5
    (state_ff.port_sel && state_ff.cfg3.far_ctl)
    |=> !second_port_pin3_oe_n_o &&
        (second_port_pin3_o == $past(far_level_i[0])) &&
        (pin_o[0] == $past(func_i[0])))
    else $error("pin 3 config not moved to second port");

  AST_PIN3_WRITE: assert property ( // RULE6
    s_wr(rpc_pkg::ADDR_PIN3)
    |=> state_ff.cfg3 == $past(pwdata_i[3:0]))
    else $error("pin 3 write not stored");

  AST_PIN56_WRITE: assert property ( // RULE7
    s_wr(rpc_pkg::ADDR_PIN56)
    |=> (state_ff.cfg5 == $past(pwdata_i[3:0])) &&
        (state_ff.cfg6 == $past(pwdata_i[7:4])))
    else $error("pins 5 and 6 write not stored");

  AST_PIN78_READ: assert property ( // RULE8
    s_rd_setup(rpc_pkg::ADDR_PIN78)
    |=> (prdata_o[0] == 1'b0) &&
        (prdata_o[7:4] == $past(state_ff.cfg8)) &&
        (prdata_o[3:1] == $past(state_ff.cfg7)))
    else $error("pins 7 and 8 read data wrong");

  AST_PIN3_RESV_READ: assert property ( // RULE9
    s_rd_setup(rpc_pkg::ADDR_PIN3) |=> prdata_o[31:4] == 28'h0)
    else $error("pin 3 reserved bits not zero");

endmodule : rpc_pin_config

// file: rpc_pkg.sv
// Package for the remote-controlled pin configuration block.
// Holds register indices, byte addresses, field layout, reset value
// and the carrier types shared by the design.
package rpc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_PIN3   = 8'h1f; // Pin 3 control
  localparam logic [7:0] IDX_PIN56  = 8'h20; // Pins 5 and 6 control
  localparam logic [7:0] IDX_PIN78  = 8'h21; // Pins 7 and 8 control
  localparam logic [7:0] IDX_PORT   = 8'h24; // Second-port select
  localparam logic [7:0] IDX_LEVEL  = 8'h25; // Sampled pin levels

  // APB byte addresses
  localparam int         ADDR_W     = 8;
  localparam logic [7:0] ADDR_PIN3  = 8'(IDX_PIN3 << 2);
  localparam logic [7:0] ADDR_PIN56 = 8'(IDX_PIN56 << 2);
  localparam logic [7:0] ADDR_PIN78 = 8'(IDX_PIN78 << 2);
  localparam logic [7:0] ADDR_PORT  = 8'(IDX_PORT << 2);
  localparam logic [7:0] ADDR_LEVEL = 8'(IDX_LEVEL << 2);

  // Field positions inside a control nibble
  localparam int F_LEVEL  = 3; // Local output level
  localparam int F_FAR    = 2; // Far-end control enable
  localparam int F_DIR    = 1; // Direction bit
  localparam int F_EN     = 0; // Function enable bit
  localparam int NIB_HI   = 4; // Upper nibble base
  localparam int NUM_PINS = 5; // Pins 3, 5, 6, 7, 8

  // Reset values
  localparam logic [7:0] RST_CTRL = 8'h00;

  // Two-bit pad code {direction, enable}
  typedef enum logic [1:0] {
    RPC_FUNC_OUT = 2'b00,
    RPC_GP_OUT   = 2'b01,
    RPC_TRISTATE = 2'b10,
    RPC_GP_IN    = 2'b11
  } rpc_mode_t;

  // One pin's control nibble, laid out as in the register
  typedef struct packed {
    logic level;
    logic far_ctl;
    logic direction;
    logic func_en;
  } rpc_cfg_t;

  // Pad drive pair
  typedef struct packed {
    logic out;
    logic oe_n;
  } rpc_pad_t;

  // Whole state of the block
  typedef struct packed {
    rpc_cfg_t                cfg3;
    rpc_cfg_t                cfg5;
    rpc_cfg_t                cfg6;
    logic [2:0]              cfg7;
    rpc_cfg_t                cfg8;
    logic                    port_sel;
    logic [NUM_PINS-1:0]     pin_out;
    logic [NUM_PINS-1:0]     pin_oe_n;
    logic                    sp_out;
    logic                    sp_oe_n;
    logic [NUM_PINS:0]       in_lvl;
    logic [31:0]             prdata;
  } rpc_state_t;

endpackage : rpc_pkg

// file: tb.sv
// Self-checking bench: APB register access and pad decode checks.
// Assumes the zero-wait APB slave described for the pin block.
`timescale 1ns/1ps
module tb;
  logic        ref_clk_i, rst_i, psel, pen, pwr, pready, perr, er;
  logic [7:0]  paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0]  pin_in, pin_o, oe_n, func, far_cmd, far;
  logic        sp_in, sp_o, sp_oe_n, sp_func;
  int          fails, compares, cycles;
  // Scenario table: pin 3, pins 5/6, pins 7/8, port select
  logic [7:0]  t3  [5] = '{8'hf9, 8'h0a, 8'h04, 8'h08, 8'h09};
  logic [7:0]  t56 [5] = '{8'h92, 8'h3b, 8'h4c, 8'h00, 8'h99};
  logic [7:0]  t78 [5] = '{8'h98, 8'h3f, 8'hc5, 8'h01, 8'h9a};
  logic [4:0]  tsel    = 5'b10110;

  rpc_pin_config i_rpc_pin_config (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(perr), .pin_i(pin_in),
    .pin_o(pin_o), .pin_oe_n_o(oe_n), .func_i(func),
    .far_level_i(far), .second_port_pin3_i(sp_in),
    .second_port_pin3_o(sp_o), .second_port_pin3_oe_n_o(sp_oe_n),
    .second_port_func_i(sp_func));
  rpc_far_model i_rpc_far_model (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .lvl_i(far_cmd),
    .far_level_o(far));

  // Free-running 100 MHz clock
  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      summarize();
    end
  end

  task automatic summarize();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", n, e, s);
      fails++;
    end
  endtask : chk

  // One APB transfer; held until pready is seen high at an edge
  task automatic apb(int w, logic [7:0] a, logic [31:0] d,
                     logic [3:0] s);
    @(posedge ref_clk_i);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= (w != 0);
    paddr  <= a;
    pwdata <= d;
    pstrb  <= s;
    @(posedge ref_clk_i);
    pen <= 1'b1;
    @(posedge ref_clk_i);
    while (pready !== 1'b1) @(posedge ref_clk_i);
    rd = prdata;
    er = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb

  // Expected {out, oe_n} of one pad from its control nibble
  function automatic logic [1:0] pad(logic [3:0] c, logic f, logic r);
    if (c[2]) return {r, 1'b0};
    case (c[1:0])
      2'b00:   return {f, 1'b0};
      2'b01:   return {c[3], 1'b0};
      default: return 2'b01;
    endcase
  endfunction : pad

  // New far and functional levels; link plus pad path take 2 edges
  task automatic set_lv(logic [4:0] v);
    @(posedge ref_clk_i);
    far_cmd <= v;
    func    <= ~v;
    sp_func <= ~v[0];
    repeat (3) @(posedge ref_clk_i);
    #1;
  endtask : set_lv

  task automatic chk_pads(logic [7:0] r3, r56, r78, logic sel);
    logic [3:0] c [5];
    logic [4:0] eo, ee;
    logic [1:0] sp;
    c[0] = sel ? 4'h0 : r3[3:0];
    c[1] = r56[3:0];
    c[2] = r56[7:4];
    c[3] = {r78[3:1], 1'b1};
    c[4] = r78[7:4];
    for (int i = 0; i < 5; i++)
      {eo[i], ee[i]} = pad(c[i], func[i], far_cmd[i]);
    sp = pad(sel ? r3[3:0] : 4'h0, sp_func, far_cmd[0]);
    chk("pin_o", 32'(pin_o), 32'(eo));
    chk("pin_oe_n", 32'(oe_n), 32'(ee));
    chk("second_pin", 32'({sp_o, sp_oe_n}), 32'(sp));
  endtask : chk_pads

  // After any reset the four control registers read zero and pads other than pin 7 (local output) are functional
  task automatic chk_rst();
    apb(0, rpc_pkg::ADDR_PIN3, 32'h0, 4'h0);
    chk("pin3_rst", rd, 32'h0);
    apb(0, rpc_pkg::ADDR_PIN56, 32'h0, 4'h0);
    chk("pin56_rst", rd, 32'h0);
    apb(0, rpc_pkg::ADDR_PIN78, 32'h0, 4'h0);
    chk("pin78_rst", rd, 32'h0);
    apb(0, rpc_pkg::ADDR_PORT, 32'h0, 4'h0);
    chk("port_rst", rd, 32'h0);
    set_lv(5'h0a);
    chk_pads(8'h00, 8'h00, 8'h00, 1'b0);
  endtask : chk_rst

  initial
  begin
    rst_i   = 1'b1;
    psel    = 1'b0;
    pen     = 1'b0;
    pwr     = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    pstrb   = 4'h0;
    pin_in  = 5'h00;
    func    = 5'h00;
    far_cmd = 5'h00;
    sp_in   = 1'b0;
    sp_func = 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    // Reset values and pad decode: functional output, pin 7 on local output
    chk_rst();
    $display("test reset done");
    // Table walk: every code, far control, reserved bits, port select
    for (int k = 0; k < 5; k++)
    begin
      apb(1, rpc_pkg::ADDR_PIN3, 32'hffffff00 | 32'(t3[k]), 4'h1);
      apb(1, rpc_pkg::ADDR_PIN56, 32'(t56[k]), 4'h1);
      apb(1, rpc_pkg::ADDR_PIN78, 32'(t78[k]), 4'h1);
      apb(1, rpc_pkg::ADDR_PORT, 32'(tsel[k]), 4'h1);
      apb(0, rpc_pkg::ADDR_PIN3, 32'h0, 4'h0);
      chk("pin3", rd, 32'(t3[k] & 8'h0f));
      apb(0, rpc_pkg::ADDR_PIN56, 32'h0, 4'h0);
      chk("pin56", rd, 32'(t56[k]));
      apb(0, rpc_pkg::ADDR_PIN78, 32'h0, 4'h0);
      chk("pin78", rd, 32'(t78[k] & 8'hfe));
      apb(0, rpc_pkg::ADDR_PORT, 32'h0, 4'h0);
      chk("port_sel", rd, 32'(tsel[k]));
      set_lv(5'h15);
      chk_pads(t3[k], t56[k], t78[k], tsel[k]);
      set_lv(5'h0a);
      chk_pads(t3[k], t56[k], t78[k], tsel[k]);
      $display("test table row %0d done", k);
    end
    // Refused accesses: no strobe, unmapped address
    apb(1, rpc_pkg::ADDR_PIN3, 32'h0f, 4'h0);
    chk("nostrb_err", 32'(er), 32'h0);
    apb(0, rpc_pkg::ADDR_PIN3, 32'h0, 4'h0);
    chk("pin3_nostrb", rd, 32'h09);
    apb(1, 8'h88, 32'hff, 4'h1);
    chk("wr_err", 32'(er), 32'h1);
    apb(0, 8'h88, 32'h0, 4'h0);
    chk("rd_err", 32'(er), 32'h1);
    chk("rd_unmapped", rd, 32'h0);
    $display("test refusal done");
    // Mid-run reset must clear the written configuration again
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    chk_rst();
    $display("test mid-run reset done");
    // Sampled pad levels
    @(posedge ref_clk_i);
    pin_in <= 5'h16; sp_in <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    apb(0, rpc_pkg::ADDR_LEVEL, 32'h0, 4'h0);
    chk("levels", rd, 32'h36);
    $display("test levels done");
    summarize();
  end
endmodule : tb
